// >>> core/plm_pkg.sv
// Package: constants, register map and carrier types of the powerline PHY management port
package plm_pkg;
  localparam int NUM_SUBCARRIERS = 72;
  localparam int SNR_W = 6;
  localparam logic [5:0] SNR_MIN_CODE = 6'h00;
  localparam logic [5:0] SNR_MAX_CODE = 6'h3f;
  localparam int SNR_FLOOR_DB = -10;
  localparam int SNR_CEIL_DB = 53;
  localparam logic [2:0] PHASE_MAX_CODE = 3'h5;
  localparam logic [2:0] MOD_QAM16 = 3'h4;
  localparam logic [2:0] DELIM_RSVD_MIN = 3'h2;
  localparam logic [4:0] ATTEN_MAX_DB = 5'h19;
  localparam logic [7:0] SLOT_SYMBOLS_RST = 8'h08;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_CONFIRM = 8'h10;
  localparam logic [7:0] REG_RX_INFO = 8'h14;
  localparam logic [7:0] REG_TX_CFG = 8'h18;
  localparam logic [7:0] REG_SNR_SEL = 8'h1c;
  localparam logic [7:0] REG_SNR_DATA = 8'h20;
  localparam logic [7:0] REG_MAP_BASE = 8'h24;
  localparam int MAP_WORDS = 3;

  // Control register fields
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_STATE_BIT = 4;
  localparam int CTRL_GO_BIT = 31;
  // Interrupt bits
  localparam int IRQ_CONFIRM = 0;
  localparam int IRQ_SENSE_UP = 1;
  localparam int IRQ_SENSE_DOWN = 2;
  localparam int IRQ_W = 3;

  typedef enum logic [1:0] {
    CMD_PARAM_QUERY = 2'h0,
    CMD_PARAM_STORE = 2'h1,
    CMD_TRANSCEIVER_STATE_CHANGE = 2'h2,
    CMD_MEDIA_SENSE_QUERY = 2'h3
  } mgmt_cmd_t;

  typedef enum logic [1:0] {
    TRX_SUCCESS = 2'h0,
    TRX_BUSY_TX = 2'h1,
    TRX_BUSY_RX = 2'h2
  } trx_status_t;

  typedef enum logic {
    RECEIVE_ONLY_STATE = 1'b0,
    TRANSMIT_ONLY_STATE = 1'b1
  } trx_state_t;

  // Metrics of a received frame
  typedef struct packed {
    logic [2:0] neighbour_phase_offset;
    logic [2:0] payload_mod_kind;
    logic payload_mod_coherence;
    logic [2:0] delimiter_kind;
  } rx_info_t;

  // Transmit settings
  typedef struct packed {
    logic [4:0] output_attenuation;
    logic [5:0] tx_gain;
    logic [2:0] payload_mod_kind;
    logic payload_mod_coherence;
    logic [2:0] delimiter_kind;
  } tx_cfg_t;
endpackage : plm_pkg

// >>> core/powerline_phy_mgmt.sv
// Management service port of a narrowband OFDM powerline PHY, with Avalon-MM registers
// Operation
// RULE1: A query confirm reports metrics of the most recently received frame.
// RULE2: One six-bit SNR value per subcarrier of last frame, 0x00 to 0x3F.
// RULE3: SNR quantised 1 dB per step, -10 dB floor, 53 dB ceiling.
// RULE4: Phase offset to last sender reported as code 0 to 5, 60 degree units.
// RULE5: Codes 0 in phase, 1-2 local leads, 3 opposite, 4-5 neighbour leads.
// RULE6: Modulation kind codes 0 robust, 1 BPSK, 2 QPSK, 3 8PSK, 4 16-QAM.
// RULE7: 16-QAM valid only in wide bandplan with coherent scheme.
// RULE8: Modulation coherence bit: 0 differential, 1 coherent.
// RULE9: Tone map one bit per subcarrier: 0 dummy data, 1 valid data.
// RULE10: Three-bit delimiter kind: 0 no ack, 1 ack, 2 to 7 reserved.
// RULE11: State request selects transmit-only or receive-only transceiver state.
// RULE12: State request answers success, or transmit-busy or receive-busy.
// RULE13: Sense query answers whether the medium is idle or busy.
// RULE14: Medium sense asserts after slot count of preamble symbols detected.
// RULE15: Medium sense returns idle when frame sync fails after preamble.
// RULE16: Output level reduced by stored attenuation, up to 25 dB.
// RULE17: Non-zero attenuation forces zero transmit gain; stored gain kept.
// RULE18: Store request keeps parameters and echoes stored values back.
// RULE19: Exactly one confirm per request; one request outstanding at a time.
module powerline_phy_mgmt #(
  parameter int NUM_SC = plm_pkg::NUM_SUBCARRIERS,
  parameter bit WIDE_BANDPLAN = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  // Receiver side, same clock
  input wire logic i_rx_frame_done,
  input wire plm_pkg::rx_info_t i_rx_info,
  input wire logic [NUM_SC-1:0] i_rx_use_map,
  input wire logic [NUM_SC*6-1:0] i_rx_snr,
  input wire logic i_preamble_symbol,
  input wire logic i_sync_found,
  input wire logic i_sync_failed,
  input wire logic i_tx_busy,
  input wire logic i_rx_busy,
  // Transceiver controls
  output logic o_tx_enable,
  output logic o_rx_enable,
  output logic o_physical_medium_sense,
  output logic [4:0] o_output_attenuation,
  output logic [5:0] o_tx_gain_applied
);
  localparam int SC_IDX_W = $clog2(NUM_SC);

  ////////////////////////////////////////////////////////////////////////////
  // Captured last-frame metrics
  plm_pkg::rx_info_t last_info;
  logic [NUM_SC-1:0] last_map;
  logic [5:0] last_snr [NUM_SC];
  logic [SC_IDX_W-1:0] snr_sel;

  // Metrics stay frozen between frames, so a late query still sees the last one
  // Snapshot on frame end; codes arrive pre-quantised 0x00..0x3f in 1 dB steps
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      last_info <= '0;
      last_map <= '0;
    end else if (i_rx_frame_done) begin
      last_info <= i_rx_info; // [RULE1] [RULE4] [RULE5] [RULE8] [RULE10]
      last_map <= i_rx_use_map; // [RULE9]
      // Out-of-range phase codes would mislead the MAC, so clamp to the top code
      if (i_rx_info.neighbour_phase_offset > plm_pkg::PHASE_MAX_CODE) begin
        last_info.neighbour_phase_offset <= plm_pkg::PHASE_MAX_CODE; // [RULE4]
      end
      // 16-QAM only legal in wide bandplan under coherent scheme
      if (i_rx_info.payload_mod_kind > plm_pkg::MOD_QAM16 ||
          (i_rx_info.payload_mod_kind == plm_pkg::MOD_QAM16 &&
           (!WIDE_BANDPLAN || !i_rx_info.payload_mod_coherence))) begin
        last_info.payload_mod_kind <= 3'h0; // [RULE6] [RULE7]
      end
    end
  end

  // Per-subcarrier SNR storage
  // One store per subcarrier; a frame end loads all of them on the same edge
  genvar g;
  generate
    for (g = 0; g < NUM_SC; g++) begin : g_snr
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          last_snr[g] <= plm_pkg::SNR_MIN_CODE;
        end else if (i_rx_frame_done) begin
          last_snr[g] <= i_rx_snr[g*6 +: 6]; // [RULE2] [RULE3]
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Physical carrier sense
  logic [7:0] slot_symbols;
  logic [7:0] pre_count;
  logic sense_up;
  logic sense_down;

  // Count preamble symbols; a sync loss wins over a symbol in the same cycle.
  // A found sync needs no action here: sense simply holds until the frame ends.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_count <= '0;
      o_physical_medium_sense <= 1'b0;
    end else if (i_sync_failed) begin
      pre_count <= '0;
      o_physical_medium_sense <= 1'b0; // [RULE15]
    end else if (i_preamble_symbol && !o_physical_medium_sense) begin
      pre_count <= pre_count + 8'h01;
      if (pre_count + 8'h01 >= slot_symbols) begin
        o_physical_medium_sense <= 1'b1; // [RULE14]
      end
    end else if (i_rx_frame_done) begin
      pre_count <= '0;
      o_physical_medium_sense <= 1'b0;
    end
  end

  // Event pulses for the interrupt status mirror the branches above; they look
  // one edge ahead so the status bit sets together with the sense output
  assign sense_up = !i_sync_failed && !o_physical_medium_sense && i_preamble_symbol &&
                    (pre_count + 8'h01 >= slot_symbols);
  assign sense_down = o_physical_medium_sense && (i_sync_failed || i_rx_frame_done);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit settings and attenuation
  // Staged write data live in the bus block until a store command commits them
  plm_pkg::tx_cfg_t tx_cfg;
  logic cfg_wr;
  logic [31:0] cfg_wdata;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_cfg <= '0;
    end else if (cfg_wr) begin
      tx_cfg <= cfg_wdata[17:0]; // [RULE18]
      // Attenuation beyond the documented range saturates
      if (cfg_wdata[17:13] > plm_pkg::ATTEN_MAX_DB) begin
        tx_cfg.output_attenuation <= plm_pkg::ATTEN_MAX_DB; // [RULE16]
      end
    end
  end

  // Gain stays stored but is suppressed while attenuation is active
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_output_attenuation <= '0;
      o_tx_gain_applied <= '0;
    end else begin
      o_output_attenuation <= tx_cfg.output_attenuation; // [RULE16]
      if (tx_cfg.output_attenuation != 5'h00) begin
        o_tx_gain_applied <= 6'h00; // [RULE17]
      end else begin
        o_tx_gain_applied <= tx_cfg.tx_gain;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command interpreter
  // Decoded go strobe, latched command, confirm word and its one-cycle event
  logic cmd_go;
  plm_pkg::mgmt_cmd_t cmd;
  logic cmd_state;
  logic [31:0] confirm;
  logic confirm_evt;
  logic cmd_pending;

  // One command per go; a go while pending is dropped so each gets one confirm
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      confirm <= '0;
      confirm_evt <= 1'b0;
      cmd_pending <= 1'b0;
      o_tx_enable <= 1'b0;
      o_rx_enable <= 1'b1;
    end else begin
      confirm_evt <= 1'b0;
      if (cmd_go && !cmd_pending) begin
        cmd_pending <= 1'b1; // [RULE19]
      end else if (cmd_pending) begin
        cmd_pending <= 1'b0;
        confirm_evt <= 1'b1; // [RULE19]
        confirm[31:30] <= cmd;
        unique case (cmd)
          plm_pkg::CMD_PARAM_QUERY: begin
            confirm[29:0] <= {20'h00000, last_info}; // [RULE1]
          end
          plm_pkg::CMD_PARAM_STORE: begin
            confirm[29:0] <= {12'h000, tx_cfg}; // [RULE18]
          end
          plm_pkg::CMD_TRANSCEIVER_STATE_CHANGE: begin
            // A busy transmitter is reported ahead of a busy receiver
            if (i_tx_busy) begin
              confirm[29:0] <= {28'h0000000, plm_pkg::TRX_BUSY_TX}; // [RULE12]
            end else if (i_rx_busy) begin
              confirm[29:0] <= {28'h0000000, plm_pkg::TRX_BUSY_RX}; // [RULE12]
            end else begin
              confirm[29:0] <= {28'h0000000, plm_pkg::TRX_SUCCESS}; // [RULE12]
              o_tx_enable <= cmd_state == plm_pkg::TRANSMIT_ONLY_STATE; // [RULE11]
              o_rx_enable <= cmd_state == plm_pkg::RECEIVE_ONLY_STATE; // [RULE11]
            end
          end
          plm_pkg::CMD_MEDIA_SENSE_QUERY: begin
            confirm[29:0] <= {29'h00000000, o_physical_medium_sense}; // [RULE13]
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle per access, answer on the second edge.
  // A write lands on the edge at which the master sees waitrequest low, so the
  // write and its answer share one edge and a held request cannot land early.
  // Register map, 32-bit words, no byte enables:
  //   0x00 control: bit31 go, bit4 target state (1 transmit-only), bits1:0 command
  //   0x04 status: write slot symbol count; read rx and tx enable, sense, count
  //   0x08 interrupt status, write one to clear: confirm, sense up, sense down
  //   0x0c interrupt mask, same layout as the status
  //   0x10 confirm word: command in bits31:30, payload below it
  //   0x14 last frame metrics, packed as the receiver hands them over
  //   0x18 transmit settings, staged until a store command commits them
  //   0x1c subcarrier select, 0x20 SNR code of the selected subcarrier
  //   0x24 to 0x2c subcarrier use map, subcarrier 0 at bit 0
  localparam int IRQ_W_L = plm_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_stat;
  logic [IRQ_W_L-1:0] irq_mask;
  logic [IRQ_W_L-1:0] irq_evt;
  logic acc_done;
  logic acc;
  logic wr_hit;
  logic [31:0] next_rdata;

  assign acc = (i_avs_read || i_avs_write) && !acc_done;
  assign wr_hit = i_avs_write && acc_done;
  assign cmd_go = wr_hit && i_avs_address == plm_pkg::REG_CTRL &&
                  i_avs_writedata[plm_pkg::CTRL_GO_BIT];
  assign cfg_wr = cmd_go && !cmd_pending &&
                  i_avs_writedata[1:0] == plm_pkg::CMD_PARAM_STORE;
  assign irq_evt = {sense_down, sense_up, confirm_evt};

  // Command fields latched with go; store data carried in a separate config write
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd <= plm_pkg::CMD_PARAM_QUERY;
      cmd_state <= 1'b0;
      cfg_wdata <= '0;
    end else if (wr_hit && i_avs_address == plm_pkg::REG_TX_CFG) begin
      cfg_wdata <= i_avs_writedata;
    end else if (cmd_go && !cmd_pending) begin
      cmd <= plm_pkg::mgmt_cmd_t'(i_avs_writedata[1:0]);
      cmd_state <= i_avs_writedata[plm_pkg::CTRL_STATE_BIT];
    end
  end

  // Configuration registers
  // Slot count shares the status offset: writes set it, reads show it back
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_mask <= '0;
      slot_symbols <= plm_pkg::SLOT_SYMBOLS_RST;
      snr_sel <= '0;
    end else if (wr_hit) begin
      unique case (i_avs_address)
        plm_pkg::REG_IRQ_MASK: irq_mask <= i_avs_writedata[IRQ_W_L-1:0];
        plm_pkg::REG_STATUS: slot_symbols <= i_avs_writedata[7:0]; // [RULE14]
        plm_pkg::REG_SNR_SEL: snr_sel <= i_avs_writedata[SC_IDX_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status: set beats a simultaneous write-one clear
  // The interrupt output lags the status by one cycle so that it leaves a flop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat <= '0;
      o_irq <= 1'b0;
    end else begin
      if (wr_hit && i_avs_address == plm_pkg::REG_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~i_avs_writedata[IRQ_W_L-1:0]) | irq_evt;
      end else begin
        irq_stat <= irq_stat | irq_evt;
      end
      o_irq <= |(irq_stat & irq_mask);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (i_avs_address)
      plm_pkg::REG_CTRL: next_rdata = {31'h00000000, cmd_pending};
      plm_pkg::REG_STATUS: next_rdata = {21'h000000, o_rx_enable, o_tx_enable,
                                         o_physical_medium_sense, slot_symbols};
      plm_pkg::REG_IRQ_STAT: next_rdata = {29'h00000000, irq_stat};
      plm_pkg::REG_IRQ_MASK: next_rdata = {29'h00000000, irq_mask};
      plm_pkg::REG_CONFIRM: next_rdata = confirm;
      plm_pkg::REG_RX_INFO: next_rdata = {22'h000000, last_info}; // [RULE1]
      plm_pkg::REG_TX_CFG: next_rdata = {14'h0000, tx_cfg};
      plm_pkg::REG_SNR_SEL: next_rdata = 32'(snr_sel);
      plm_pkg::REG_SNR_DATA: next_rdata = {26'h0000000,
        (int'(snr_sel) < NUM_SC) ? last_snr[snr_sel] : 6'h00}; // [RULE2]
      default: begin
        // Map words; bits past the last subcarrier read zero
        for (int w = 0; w < plm_pkg::MAP_WORDS; w++) begin
          if (i_avs_address == plm_pkg::REG_MAP_BASE + 8'(w * 4)) begin
            for (int b = 0; b < 32; b++) begin
              if (w * 32 + b < NUM_SC) begin
                next_rdata[b] = last_map[w * 32 + b]; // [RULE9]
              end
            end
          end
        end
      end
    endcase
  end

  // Handshake: waitrequest high by default, drops one cycle after request
  // Read data are captured on the edge that drops waitrequest, one edge before the taking edge, and stand until the next access
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_done <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= '0;
    end else begin
      acc_done <= acc;
      o_avs_waitrequest <= !acc;
      if (acc) begin
        o_avs_readdata <= next_rdata;
      end
    end
  end
endmodule : powerline_phy_mgmt

// >>> dv/powerline_phy_mgmt_checker.sv
// Checker: port-level assertions of the powerline PHY management block
module powerline_phy_mgmt_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_preamble_symbol,
  input wire logic i_sync_failed,
  input wire logic i_rx_frame_done,
  input wire logic o_tx_enable,
  input wire logic o_rx_enable,
  input wire logic o_physical_medium_sense,
  input wire logic [4:0] o_output_attenuation,
  input wire logic [5:0] o_tx_gain_applied
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Every access gets exactly one answer cycle, and only when asked
  property p_one_answer;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("access not answered");
  property p_answer_short;
    !o_avs_waitrequest |-> $past(i_avs_read || i_avs_write) ##1 o_avs_waitrequest;
  endproperty
  a_answer_short: assert property (p_answer_short) else $error("stray answer");
  // Transceiver is either sending or listening, never both
  property p_trx_excl;
    o_tx_enable != o_rx_enable;
  endproperty
  a_trx_excl: assert property (p_trx_excl) else $error("transceiver state clash");
  // Attenuation caps and gain suppression
  property p_atten_max;
    o_output_attenuation <= plm_pkg::ATTEN_MAX_DB;
  endproperty
  a_atten_max: assert property (p_atten_max) else $error("attenuation above cap");
  property p_gain_off;
    |o_output_attenuation |-> o_tx_gain_applied == 6'h00;
  endproperty
  a_gain_off: assert property (p_gain_off) else $error("gain while attenuated");
  // Medium sense rises only on a counted preamble symbol
  property p_sense_up;
    $rose(o_physical_medium_sense) |-> $past(i_preamble_symbol);
  endproperty
  a_sense_up: assert property (p_sense_up) else $error("sense rose without preamble");
  property p_sense_clr;
    i_sync_failed && !i_preamble_symbol |=> !o_physical_medium_sense;
  endproperty
  a_sense_clr: assert property (p_sense_clr) else $error("sense kept after sync loss");
  property p_sense_fall;
    $fell(o_physical_medium_sense) |-> $past(i_sync_failed || i_rx_frame_done);
  endproperty
  a_sense_fall: assert property (p_sense_fall) else $error("sense fell without cause");
  // Main scenarios reached
  c_write: cover property (i_avs_write && !o_avs_waitrequest);
  c_sense: cover property ($rose(o_physical_medium_sense));
  c_atten: cover property (|o_output_attenuation);
endmodule : powerline_phy_mgmt_checker

bind powerline_phy_mgmt powerline_phy_mgmt_checker powerline_phy_mgmt_checker_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .i_preamble_symbol(i_preamble_symbol),
  .i_sync_failed(i_sync_failed), .i_rx_frame_done(i_rx_frame_done),
  .o_tx_enable(o_tx_enable), .o_rx_enable(o_rx_enable),
  .o_physical_medium_sense(o_physical_medium_sense),
  .o_output_attenuation(o_output_attenuation), .o_tx_gain_applied(o_tx_gain_applied));

// >>> dv/rx_frontend_model.sv
// Receiver front-end model: frame metrics, preamble symbols and sync loss
module rx_frontend_model #(
  parameter int NUM_SC = plm_pkg::NUM_SUBCARRIERS
) (
  input wire logic i_clk,
  output logic o_frame_done,
  output plm_pkg::rx_info_t o_rx_info,
  output logic [NUM_SC-1:0] o_rx_use_map,
  output logic [NUM_SC*6-1:0] o_rx_snr,
  output logic o_preamble_symbol,
  output logic o_sync_failed
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines idle low until the first frame
  initial begin
    o_frame_done = 1'b0;
    o_rx_info = '0;
    o_rx_use_map = '0;
    o_rx_snr = '0;
    o_preamble_symbol = 1'b0;
    o_sync_failed = 1'b0;
  end
  // Metrics hold only in the done cycle; then inverted so a late capture shows up
  task automatic frame(input plm_pkg::rx_info_t ri, input logic [NUM_SC-1:0] m,
                       input logic [NUM_SC*6-1:0] s);
    @(posedge i_clk);
    o_rx_info <= ri;
    o_rx_use_map <= m;
    o_rx_snr <= s;
    o_frame_done <= 1'b1;
    @(posedge i_clk);
    o_rx_info <= ~ri;
    o_rx_use_map <= ~m;
    o_rx_snr <= ~s;
    o_frame_done <= 1'b0;
  endtask : frame
  // One-cycle pulse per detected preamble symbol
  task automatic preamble(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_preamble_symbol <= 1'b1;
      @(posedge i_clk);
      o_preamble_symbol <= 1'b0;
    end
  endtask : preamble
  // Frame synchronisation lost after the preamble
  task automatic sync_fail();
    @(posedge i_clk);
    o_sync_failed <= 1'b1;
    @(posedge i_clk);
    o_sync_failed <= 1'b0;
  endtask : sync_fail
endmodule : rx_frontend_model

// >>> dv/powerline_phy_mgmt_tb.sv
// Testbench: register-level scenarios for the powerline PHY management block
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module powerline_phy_mgmt_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, rd, wr_en, tx_busy, rx_busy, waitreq, irq, tx_en, rx_en, sense;
  logic done, pre, sfail;
  logic [7:0] addr;
  logic [31:0] wdat, rdat, readdata;
  logic [4:0] atten;
  logic [5:0] gain;
  logic [71:0] map, rmap;
  logic [431:0] snr, rsnr;
  plm_pkg::rx_info_t ri, ex, rinfo;
  int fail_count, checks;
  int scs[5] = '{0, 1, 62, 63, 71};
  ////////////////////////////////////////////////////////////////////////////////
  powerline_phy_mgmt powerline_phy_mgmt_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr_en), .i_avs_writedata(wdat), .o_avs_readdata(readdata),
    .o_avs_waitrequest(waitreq), .o_irq(irq), .i_rx_frame_done(done), .i_rx_info(rinfo),
    .i_rx_use_map(rmap), .i_rx_snr(rsnr), .i_preamble_symbol(pre), .i_sync_found(1'b0),
    .i_sync_failed(sfail), .i_tx_busy(tx_busy), .i_rx_busy(rx_busy), .o_tx_enable(tx_en),
    .o_rx_enable(rx_en), .o_physical_medium_sense(sense), .o_output_attenuation(atten),
    .o_tx_gain_applied(gain));
  rx_frontend_model rx_frontend_model_i (
    .i_clk(i_clk), .o_frame_done(done), .o_rx_info(rinfo), .o_rx_use_map(rmap),
    .o_rx_snr(rsnr), .o_preamble_symbol(pre), .o_sync_failed(sfail));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; the run needs a few hundred cycles at most
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    #40000;
    fail_count++;
    test_done();
  end
  // Bus access: hold the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge i_clk);
    addr <= a;
    wdat <= v;
    wr_en <= w;
    rd <= !w;
    do begin
      @(posedge i_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    rdat = readdata;
    if (n >= 20) fail_count++;
    wr_en <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask : rd_chk
  // Issue a command and compare its confirm word
  task automatic cmd(input logic [31:0] c, input logic [31:0] e);
    wr(plm_pkg::REG_CTRL, c);
    rd_chk(plm_pkg::REG_CONFIRM, e);
  endtask : cmd
  // Stage transmit settings, commit them with a store command, check the echo
  task automatic store(input logic [31:0] v, input logic [31:0] e);
    wr(plm_pkg::REG_TX_CFG, v);
    cmd(32'h8000_0001, e);
    settle();
  endtask : store
  // Let registered outputs land before looking at them
  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic test_done();
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    i_rst = 1'b1;
    rd = 1'b0;
    wr_en = 1'b0;
    addr = 8'h00;
    wdat = 32'h0;
    tx_busy = 1'b0;
    rx_busy = 1'b0;
    map = 72'ha5_0123_4567_89ab_cdef;
    for (int c = 0; c < 72; c++) snr[c*6 +: 6] = 6'(c % 64);
    repeat (2) @(posedge i_clk);
    `CHK({tx_en, rx_en, sense, atten, gain}, 14'h1000)
    i_rst <= 1'b0;
    rd_chk(plm_pkg::REG_STATUS, 32'h0000_0408);
    rd_chk(8'h80, 32'h0);
    // Frame metrics: every phase and delimiter code, illegal 16-QAM dropped
    for (int k = 0; k < 10; k++) begin
      ri = {3'(k), 3'(k % 5), k != 4, 3'(k)};
      ex = ri;
      if (ri.neighbour_phase_offset > plm_pkg::PHASE_MAX_CODE) ex.neighbour_phase_offset = 3'h5;
      if (k == 4) ex.payload_mod_kind = 3'h0;
      rx_frontend_model_i.frame(ri, map, snr);
      cmd(32'h8000_0000, {22'h0, ex});
      rd_chk(plm_pkg::REG_RX_INFO, {22'h0, ex});
    end
    rd_chk(plm_pkg::REG_MAP_BASE, 32'h89ab_cdef);
    rd_chk(8'h28, 32'h0123_4567);
    rd_chk(8'h2c, 32'h0000_00a5);
    foreach (scs[j]) begin
      wr(plm_pkg::REG_SNR_SEL, 32'(scs[j]));
      rd_chk(plm_pkg::REG_SNR_DATA, 32'(scs[j] % 64));
    end
    // Transceiver state: success, then refused while busy
    cmd(32'h8000_0012, 32'h8000_0000);
    settle();
    `CHK({tx_en, rx_en}, 2'b10)
    for (int b = 1; b < 4; b++) begin
      tx_busy <= b[1];
      rx_busy <= b[0];
      cmd(32'h8000_0002, 32'h8000_0000 | (b[1] ? 32'h1 : 32'h2));
    end
    tx_busy <= 1'b0;
    rx_busy <= 1'b0;
    cmd(32'h8000_0002, 32'h8000_0000);
    settle();
    `CHK({tx_en, rx_en}, 2'b01)
    // Attenuation, gain suppression and store echo
    store(32'h0000_0aa9, 32'h4000_0aa9);
    `CHK({atten, gain}, 11'h015)
    store(32'h0001_4aa9, 32'h4001_4aa9);
    `CHK({atten, gain}, {5'h0a, 6'h00})
    cmd(32'h8000_0001, 32'h4001_4aa9);
    store(32'h0003_eaa9, 32'h4003_2aa9);
    `CHK({atten, gain}, {plm_pkg::ATTEN_MAX_DB, 6'h00})
    store(32'h0000_0aa9, 32'h4000_0aa9);
    `CHK(gain, 6'h15)
    wr(plm_pkg::REG_TX_CFG, 32'h0001_4aa9);
    settle();
    `CHK(gain, 6'h15)
    // Medium sense after slot count of preamble symbols, cleared by sync loss
    wr(plm_pkg::REG_STATUS, 32'h3);
    rx_frontend_model_i.preamble(2);
    cmd(32'h8000_0003, 32'hc000_0000);
    rx_frontend_model_i.preamble(1);
    settle();
    `CHK(sense, 1'b1)
    cmd(32'h8000_0003, 32'hc000_0001);
    rd_chk(plm_pkg::REG_STATUS, 32'h0000_0503);
    rx_frontend_model_i.sync_fail();
    settle();
    `CHK(sense, 1'b0)
    // Interrupt: sticky events, mask, write-one-to-clear
    rd_chk(plm_pkg::REG_IRQ_STAT, 32'h7);
    `CHK(irq, 1'b0)
    wr(plm_pkg::REG_IRQ_MASK, 32'h2);
    settle();
    `CHK(irq, 1'b1)
    wr(plm_pkg::REG_IRQ_STAT, 32'h2);
    settle();
    `CHK(irq, 1'b0)
    rd_chk(plm_pkg::REG_IRQ_STAT, 32'h5);
    test_done();
  end
endmodule : powerline_phy_mgmt_tb
